// ===== src/ccix_consts.vh
// Purpose: shared constants of the card command issue block
// Assumes: 50 MHz system clock, APB with 32-bit data
// Notes: offsets are byte addresses of aligned words
`ifndef CCIX_CONSTS_VH
`define CCIX_CONSTS_VH

// register byte offsets
`define CCIX_OFF_CMD 12'h000
`define CCIX_OFF_ARG 12'h004
`define CCIX_OFF_BSIZE 12'h008
`define CCIX_OFF_BCOUNT 12'h00c
`define CCIX_OFF_STATUS 12'h010
`define CCIX_OFF_XCOUNT 12'h014

// command word fields
`define CCIX_CMD_IDX_HI 5
`define CCIX_CMD_IDX_LO 0
`define CCIX_CMD_PPULL 7
`define CCIX_CMD_BUSY 8
`define CCIX_CMD_RSP_LO 9
`define CCIX_CMD_RSP_HI 10
`define CCIX_CMD_DIR 11
`define CCIX_CMD_STREAM 12
`define CCIX_CMD_DATA 13
// writable bits of the command word; the rest reads as zero
`define CCIX_CMD_MASK 32'h00003fbf

// argument halves
`define CCIX_ARG_UP_HI 31
`define CCIX_ARG_UP_LO 16
`define CCIX_ARG_LO_HI 15
`define CCIX_ARG_LO_LO 0

// response types
`define CCIX_RSP_NONE 2'h0
`define CCIX_RSP_48_CRC 2'h1
`define CCIX_RSP_136_CRC 2'h2
`define CCIX_RSP_48_NOCRC 2'h3

// reset values
`define CCIX_RST_CMD 32'h00000000
`define CCIX_RST_ARG 32'h00000000
`define CCIX_RST_BSIZE 12'h200
`define CCIX_RST_BCOUNT 16'h0001

// frame layout
`define CCIX_FRAME_BITS 6'd48
`define CCIX_CRC_POS 6'd8
`define CCIX_STOP_INDEX 6'd12
`define CCIX_CRC_POLY 7'h09

// card clock timing
`define CCIX_SYS_PERIOD_NS 20
`define CCIX_CARD_HALF_NS 80
`define CCIX_HALF_CYC ((`CCIX_CARD_HALF_NS) / (`CCIX_SYS_PERIOD_NS))

`endif

// ===== src/ccix_crc7.v
// Purpose: serial crc7, polynomial x^7 + x^3 + 1
// Assumes: one data bit per enable, msb first
// Notes: clear wins over enable
`timescale 1ns/100ps
`default_nettype none
`include "ccix_consts.vh"
module ccix_crc7 (
   // clock and reset
   input wire i_clk,
   input wire i_rst_n,
   // control and data
   input wire i_clear,
   input wire i_en,
   input wire i_bit,
   output reg [6:0] o_crc
);
   wire fb;

   assign fb = i_bit ^ o_crc[6];

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_crc <= 7'h00;
      end else if (i_clear) begin
         o_crc <= 7'h00;
      end else if (i_en) begin
         o_crc <= {o_crc[5:0], 1'b0} ^ (fb ? `CCIX_CRC_POLY : 7'h00);
      end
   end
endmodule
`default_nettype wire

// ===== src/ccix_sync.v
// Purpose: two-stage level synchroniser
// Assumes: input is asynchronous to i_clk
// Notes: first stage feeds only the second
`timescale 1ns/100ps
`default_nettype none
module ccix_sync (
   // clock and reset
   input wire i_clk,
   input wire i_rst_n,
   // level in and out
   input wire i_d,
   output reg o_q
);
   reg meta_q;

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= 1'b1;
         o_q <= 1'b1;
      end else begin
         meta_q <= i_d;
         o_q <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ===== src/ccix_top.v
// Purpose: card command issue, APB registers to serial command frame
// Assumes: card clock derived here; data path and response capture outside
// Notes: command line changes on falling card clock edges
`timescale 1ns/100ps
`default_nettype none
`include "ccix_consts.vh"
module ccix_top (
   // system
   input wire I_CLK_SYS,
   input wire I_RST_N,
   // apb slave
   input wire I_PSEL,
   input wire I_PENABLE,
   input wire I_PWRITE,
   input wire [11:0] I_PADDR,
   input wire [31:0] I_PWDATA,
   output reg [31:0] O_PRDATA,
   output reg O_PREADY,
   output reg O_PSLVERR,
   // card link
   output reg O_CARD_CLK,
   input wire I_CMD_IN,
   output reg O_CMD_OUT,
   output reg O_CMD_OE,
   // data path side
   input wire I_DATA_BYTE,
   output reg O_CMD_SENT,
   output reg O_XFER_ACTIVE,
   output reg O_XFER_WRITE,
   output reg O_XFER_STREAM,
   output reg O_XFER_DONE,
   output reg [1:0] O_RESP_TYPE,
   output reg O_BUSY_EXPECTED
);
   localparam ST_IDLE = 2'd0;
   localparam ST_WAIT = 2'd1;
   localparam ST_SEND = 2'd2;
   // last divider count of a half card period
   localparam [31:0] DIV_LAST_W = `CCIX_HALF_CYC - 1;
   localparam [2:0] DIV_LAST = DIV_LAST_W[2:0];

   reg [31:0] cmd_word_q;
   reg [31:0] arg_q;
   reg [11:0] bsize_q;
   reg [15:0] bcount_q;
   reg [1:0] state_q;
   reg [47:0] shift_q;
   reg [5:0] bit_cnt_q;
   reg [2:0] div_q;
   reg [27:0] xcount_q;
   reg [27:0] xtotal_q;
   reg refused_q;
   wire cmd_level;
   wire [6:0] crc;
   wire setup;
   wire access;
   wire wr_cmd;
   wire fall_tick;
   wire tx_bit;
   wire crc_en;
   wire crc_clr;
   wire addr_ok;
   wire [27:0] total;
   reg [31:0] rd_mux;

   assign setup = I_PSEL && !I_PENABLE;
   assign access = I_PSEL && I_PENABLE && O_PREADY;
   assign addr_ok = (I_PADDR == `CCIX_OFF_CMD) || (I_PADDR == `CCIX_OFF_ARG) ||
                    (I_PADDR == `CCIX_OFF_BSIZE) || (I_PADDR == `CCIX_OFF_BCOUNT) ||
                    (I_PADDR == `CCIX_OFF_STATUS) || (I_PADDR == `CCIX_OFF_XCOUNT);
   // a new command is refused while one is still on the line
   assign wr_cmd = access && I_PWRITE && (I_PADDR == `CCIX_OFF_CMD) && (state_q == ST_IDLE);
   assign fall_tick = (div_q == DIV_LAST) && O_CARD_CLK;
   // operands widened so the product keeps all 28 bits
   assign total = {16'h0000, bsize_q} * {12'h000, bcount_q};

   ccix_sync u_cmd_sync (
      .i_clk(I_CLK_SYS),
      .i_rst_n(I_RST_N),
      .i_d(I_CMD_IN),
      .o_q(cmd_level)
   );

   // crc over frame bits 47 to 8
   assign crc_en = fall_tick && (state_q == ST_SEND) && (bit_cnt_q > `CCIX_CRC_POS);
   assign crc_clr = wr_cmd;

   ccix_crc7 u_crc (
      .i_clk(I_CLK_SYS),
      .i_rst_n(I_RST_N),
      .i_clear(crc_clr),
      .i_en(crc_en),
      .i_bit(shift_q[47]),
      .o_crc(crc)
   );

   // crc msb leaves at the bit count where data ends
   assign tx_bit = (bit_cnt_q == `CCIX_CRC_POS) ? crc[6] : shift_q[47];

   always @* begin
      rd_mux = 32'h00000000;
      case (I_PADDR)
         `CCIX_OFF_CMD: rd_mux = cmd_word_q;
         `CCIX_OFF_ARG: rd_mux = arg_q;
         `CCIX_OFF_BSIZE: rd_mux = {20'h00000, bsize_q};
         `CCIX_OFF_BCOUNT: rd_mux = {16'h0000, bcount_q};
         `CCIX_OFF_STATUS: rd_mux = {28'h0000000, refused_q, cmd_level,
                                     O_XFER_ACTIVE, (state_q != ST_IDLE)};
         `CCIX_OFF_XCOUNT: rd_mux = {4'h0, xcount_q};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // apb: one wait-free access phase, answer prepared in setup
   always @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_PREADY <= 1'b0;
         O_PRDATA <= 32'h00000000;
         O_PSLVERR <= 1'b0;
      end else begin
         O_PREADY <= setup;
         if (setup) begin
            O_PRDATA <= I_PWRITE ? 32'h00000000 : rd_mux;
            O_PSLVERR <= !addr_ok;
         end else if (!I_PSEL) begin
            O_PSLVERR <= 1'b0;
         end
      end
   end

   // register writes
   always @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         cmd_word_q <= `CCIX_RST_CMD;
         arg_q <= `CCIX_RST_ARG;
         bsize_q <= `CCIX_RST_BSIZE;
         bcount_q <= `CCIX_RST_BCOUNT;
         refused_q <= 1'b0;
      end else if (access && I_PWRITE) begin
         case (I_PADDR)
            `CCIX_OFF_CMD: begin
               // write while sending is refused and flagged
               if (state_q == ST_IDLE) begin
                  cmd_word_q <= I_PWDATA & `CCIX_CMD_MASK;
                  refused_q <= 1'b0;
               end else begin
                  refused_q <= 1'b1;
               end
            end
            `CCIX_OFF_ARG: arg_q <= I_PWDATA;
            `CCIX_OFF_BSIZE: bsize_q <= I_PWDATA[11:0];
            `CCIX_OFF_BCOUNT: bcount_q <= I_PWDATA[15:0];
            default: bsize_q <= bsize_q;
         endcase
      end
   end

   // card clock divider; free running so the card sees clocks at idle
   always @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         div_q <= 3'd0;
         O_CARD_CLK <= 1'b0;
      end else if (div_q == DIV_LAST) begin
         div_q <= 3'd0;
         O_CARD_CLK <= !O_CARD_CLK;
      end else begin
         div_q <= div_q + 3'd1;
      end
   end

   // frame sender
   always @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         state_q <= ST_IDLE;
         shift_q <= 48'h000000000000;
         bit_cnt_q <= 6'd0;
         O_CMD_OUT <= 1'b1;
         O_CMD_OE <= 1'b0;
         O_CMD_SENT <= 1'b0;
      end else begin
         O_CMD_SENT <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (wr_cmd) begin
                  // index into 45..40, start 0, transmission 1
                  // argument is copied, its register left as is
                  shift_q <= {2'b01, I_PWDATA[`CCIX_CMD_IDX_HI:`CCIX_CMD_IDX_LO],
                              arg_q[`CCIX_ARG_UP_HI:`CCIX_ARG_UP_LO],
                              arg_q[`CCIX_ARG_LO_HI:`CCIX_ARG_LO_LO], 8'h00};
                  bit_cnt_q <= `CCIX_FRAME_BITS;
                  state_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (fall_tick) begin
                  state_q <= ST_SEND;
               end
            end
            ST_SEND: begin
               if (fall_tick) begin
                  if (bit_cnt_q == 6'd0) begin
                     O_CMD_OE <= 1'b0;
                     O_CMD_OUT <= 1'b1;
                     O_CMD_SENT <= 1'b1;
                     state_q <= ST_IDLE;
                  end else begin
                     // push pull drives both levels, open drain only low
                     if (cmd_word_q[`CCIX_CMD_PPULL]) begin
                        O_CMD_OUT <= tx_bit;
                        O_CMD_OE <= 1'b1;
                     end else begin
                        O_CMD_OUT <= 1'b0;
                        O_CMD_OE <= !tx_bit;
                     end
                     // crc then end bit 1 after data bits
                     if (bit_cnt_q == `CCIX_CRC_POS) begin
                        shift_q <= {crc[5:0], 1'b1, 41'h00000000000};
                     end else begin
                        shift_q <= {shift_q[46:0], 1'b0};
                     end
                     bit_cnt_q <= bit_cnt_q - 6'd1;
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // response set-up follows the command word
   always @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_RESP_TYPE <= `CCIX_RSP_NONE;
         O_BUSY_EXPECTED <= 1'b0;
      end else begin
         O_RESP_TYPE <= cmd_word_q[`CCIX_CMD_RSP_HI:`CCIX_CMD_RSP_LO];
         O_BUSY_EXPECTED <= cmd_word_q[`CCIX_CMD_BUSY];
      end
   end

   // data transfer tracking, armed when the frame has gone out
   always @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_XFER_ACTIVE <= 1'b0;
         O_XFER_WRITE <= 1'b0;
         O_XFER_STREAM <= 1'b0;
         O_XFER_DONE <= 1'b0;
         xcount_q <= 28'h0000000;
         xtotal_q <= 28'h0000000;
      end else begin
         O_XFER_DONE <= 1'b0;
         if (O_CMD_SENT) begin
            // stop command ends a running stream
            if (O_XFER_ACTIVE && O_XFER_STREAM &&
                (cmd_word_q[`CCIX_CMD_IDX_HI:`CCIX_CMD_IDX_LO] == `CCIX_STOP_INDEX)) begin
               O_XFER_ACTIVE <= 1'b0;
               O_XFER_DONE <= 1'b1;
            // only a command with data starts a transfer
            end else if (cmd_word_q[`CCIX_CMD_DATA]) begin
               O_XFER_WRITE <= cmd_word_q[`CCIX_CMD_DIR];
               O_XFER_STREAM <= cmd_word_q[`CCIX_CMD_STREAM];
               xcount_q <= 28'h0000000;
               xtotal_q <= total;
               // an empty block transfer completes at once
               if (!cmd_word_q[`CCIX_CMD_STREAM] && (total == 28'h0000000)) begin
                  O_XFER_ACTIVE <= 1'b0;
                  O_XFER_DONE <= 1'b1;
               end else begin
                  O_XFER_ACTIVE <= 1'b1;
               end
            end
         end else if (O_XFER_ACTIVE && I_DATA_BYTE) begin
            xcount_q <= xcount_q + 28'h0000001;
            // block transfer ends on its byte total
            if (!O_XFER_STREAM && (xcount_q + 28'h0000001 == xtotal_q)) begin
               O_XFER_ACTIVE <= 1'b0;
               O_XFER_DONE <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/ccix_card_model.sv
// Purpose: card end of the command line, captures each frame
// Assumes: card clock is slow enough for the system clock to see
// Notes: never answers, so the line rests at its pull-up
`timescale 1ns/100ps
`default_nettype none
module ccix_card_model (
   // system
   input wire logic i_clk,
   input wire logic i_rst_n,
   // card link
   input wire logic i_card_clk,
   input wire logic i_cmd,
   // captured frame
   output logic [47:0] o_frame
);
   logic clk_q;
   logic busy_q;
   logic [5:0] n_q;
   logic [45:0] sh_q;
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         clk_q <= 1'b0;
         busy_q <= 1'b0;
         n_q <= 6'h00;
         sh_q <= '0;
         o_frame <= '0;
      end else begin
         clk_q <= i_card_clk;
         if (i_card_clk && !clk_q) begin
            if (!busy_q && !i_cmd) begin
               busy_q <= 1'b1;
               n_q <= 6'h01;
            end else if (busy_q) begin
               sh_q <= {sh_q[44:0], i_cmd};
               n_q <= n_q + 6'h01;
               if (n_q == 6'h2f) begin
                  busy_q <= 1'b0;
                  o_frame <= {1'b0, sh_q, i_cmd};
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/ccix_top_assertions.sv
// Purpose: port-level checks of the card command issue block
// Assumes: software keeps one command in flight at a time
// Notes: helper flags shadow the last accepted command word
`timescale 1ns/100ps
`default_nettype none
module ccix_top_chk (
   // system
   input wire logic I_CLK_SYS,
   input wire logic I_RST_N,
   // apb
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [11:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic O_PREADY,
   // card and data side
   input wire logic O_CMD_OUT,
   input wire logic O_CMD_OE,
   input wire logic O_CMD_SENT,
   input wire logic O_XFER_ACTIVE,
   input wire logic O_XFER_WRITE,
   input wire logic O_XFER_STREAM,
   input wire logic O_XFER_DONE,
   input wire logic [1:0] O_RESP_TYPE,
   input wire logic O_BUSY_EXPECTED
);
   reg busy_q;
   reg [13:7] cw_q;
   wire wr_cmd;
   wire line_hi;
   // a write while busy is refused; the sender is idle again in the sent-pulse cycle
   assign wr_cmd = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == 12'h000 &&
                   (!busy_q || O_CMD_SENT);
   assign line_hi = !O_CMD_OE || O_CMD_OUT;
   always @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         busy_q <= 1'b0;
         cw_q <= 7'h00;
      end else if (wr_cmd) begin
         busy_q <= 1'b1;
         cw_q <= I_PWDATA[13:7];
      end else if (O_CMD_SENT) begin
         busy_q <= 1'b0;
      end
   end
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RST_N);
   a_rsp_copy: assert property (wr_cmd |-> ##2 O_RESP_TYPE == $past(I_PWDATA[10:9], 2))
      else $error("response type differs from command word");
   a_busy_copy: assert property (wr_cmd |-> ##2 O_BUSY_EXPECTED == $past(I_PWDATA[8], 2))
      else $error("busy flag differs from command word");
   // start bit waits for one divider tick, then one more card clock
   a_frame_start: assert property (wr_cmd |-> ##[1:17] (O_CMD_OE && !O_CMD_OUT))
      else $error("no start bit after command write");
   a_open_drain: assert property (O_CMD_OE && !cw_q[7] |-> !O_CMD_OUT)
      else $error("open drain mode drives a one");
   a_push_pull: assert property ($rose(O_CMD_OE) && cw_q[7] |-> O_CMD_OE [*8])
      else $error("push pull driver released early");
   a_end_bit: assert property (O_CMD_SENT |-> $past(line_hi) && $past(line_hi, 3))
      else $error("end bit not high");
   a_xfer_kind: assert property ($rose(O_XFER_ACTIVE) |->
      O_XFER_WRITE == cw_q[11] && O_XFER_STREAM == cw_q[12])
      else $error("transfer kind differs from command word");
   a_no_data: assert property (O_CMD_SENT && !cw_q[13] && !O_XFER_ACTIVE
      |=> !O_XFER_ACTIVE)
      else $error("transfer started without data bit");
   a_data_go: assert property (O_CMD_SENT && cw_q[13] && !O_XFER_ACTIVE
      |=> O_XFER_ACTIVE || O_XFER_DONE)
      else $error("data command did not start transfer");
   a_stream_hold: assert property (O_XFER_ACTIVE && O_XFER_STREAM && !O_CMD_SENT
      |=> O_XFER_ACTIVE)
      else $error("stream ended without stop command");
endmodule
bind ccix_top ccix_top_chk u_ccix_top_chk (
   .I_CLK_SYS, .I_RST_N, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PREADY,
   .O_CMD_OUT, .O_CMD_OE, .O_CMD_SENT, .O_XFER_ACTIVE, .O_XFER_WRITE, .O_XFER_STREAM,
   .O_XFER_DONE, .O_RESP_TYPE, .O_BUSY_EXPECTED);
`default_nettype wire

// ===== tb/ccix_top_tb.sv
// Purpose: self-checking bench for the card command issue block
// Assumes: apb slave may stretch the access phase
// Notes: the command line has a pull-up; the card only listens
`timescale 1ns/100ps
`default_nettype none
`include "ccix_consts.vh"
module ccix_top_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic dbyte = 1'b0;
   logic [11:0] padr = 12'h000;
   logic [31:0] pwd = 32'h0;
   logic [31:0] rd;
   logic er;
   logic [39:0] msg;
   wire [31:0] prd;
   wire prdy, perr, cclk, cout, coe, sent, act, xwr, xstr, done, bexp;
   wire [1:0] rsp;
   wire [47:0] frame;
   wire cwire = coe ? cout : 1'b1;
   int err_total = 0;
   int checks = 0;
   int cyc = 0;
   logic [31:0] cw [4] = '{32'h0, 32'h3a9, 32'h1c3f, 32'hffffc6c1};
   logic [31:0] ag [4] = '{32'h0, 32'h12345678, 32'hffffffff, 32'ha5c30f96};
   logic [11:0] ro [5] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h0f0};
   logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h200, 32'h1, 32'h0};
   ccix_top u_ccix_top (
      .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
      .I_PADDR(padr), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr),
      .O_CARD_CLK(cclk), .I_CMD_IN(cwire), .O_CMD_OUT(cout), .O_CMD_OE(coe),
      .I_DATA_BYTE(dbyte), .O_CMD_SENT(sent), .O_XFER_ACTIVE(act), .O_XFER_WRITE(xwr),
      .O_XFER_STREAM(xstr), .O_XFER_DONE(done), .O_RESP_TYPE(rsp), .O_BUSY_EXPECTED(bexp));
   ccix_card_model u_ccix_card_model (
      .i_clk(clk), .i_rst_n(rst_n), .i_card_clk(cclk), .i_cmd(cwire), .o_frame(frame));
   always #10 clk = ~clk;
   task complete_run;
      if (err_total == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         err_total++;
         complete_run();
      end
   end
   task chk(input string n, input logic [47:0] e, input logic [47:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   // entered just after an edge; one idle edge at the end
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (prdy !== 1'b1) @(posedge clk);
      rd = prd;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task wait_sent;
      @(posedge clk);
      while (sent !== 1'b1) @(posedge clk);
      @(posedge clk);
   endtask
   task bytes(input int n);
      repeat (n) begin
         dbyte <= 1'b1;
         @(posedge clk);
         dbyte <= 1'b0;
         @(posedge clk);
      end
   endtask
   function automatic logic [6:0] crc7(input logic [39:0] m);
      logic [6:0] c;
      logic fb;
      c = 7'h00;
      for (int i = 39; i >= 0; i--) begin
         fb = m[i] ^ c[6];
         c = {c[5:0], 1'b0} ^ (fb ? `CCIX_CRC_POLY : 7'h00);
      end
      return c;
   endfunction
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, ro[i], 32'h0);
         chk("reset_val", rv[i], rd);
      end
      chk("slverr", 1, er);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `CCIX_OFF_ARG, ag[i]);
         apb(1'b1, `CCIX_OFF_CMD, cw[i]);
         apb(1'b1, `CCIX_OFF_CMD, 32'h3f);
         apb(1'b0, `CCIX_OFF_STATUS, 32'h0);
         chk("refused", 1, rd[3]);
         chk("busy_st", 1, rd[0]);
         apb(1'b0, `CCIX_OFF_ARG, 32'h0);
         chk("arg", ag[i], rd);
         apb(1'b0, `CCIX_OFF_CMD, 32'h0);
         chk("cmd", cw[i] & `CCIX_CMD_MASK, rd);
         chk("rsp_type", cw[i][`CCIX_CMD_RSP_HI:`CCIX_CMD_RSP_LO], rsp);
         chk("busy_exp", cw[i][`CCIX_CMD_BUSY], bexp);
         wait_sent();
         msg = {2'b01, cw[i][5:0], ag[i]};
         chk("frame", {msg, crc7(msg), 1'b1}, frame);
         chk("no_xfer", 0, act);
      end
      apb(1'b1, `CCIX_OFF_BSIZE, 32'h4);
      apb(1'b1, `CCIX_OFF_BCOUNT, 32'h2);
      apb(1'b1, `CCIX_OFF_CMD, 32'h2812);
      apb(1'b0, `CCIX_OFF_STATUS, 32'h0);
      chk("refused_clr", 0, rd[3]);
      wait_sent();
      chk("blk_start", 1, act);
      chk("wr_dir", 1, xwr);
      bytes(7);
      chk("blk_run", 1, act);
      bytes(1);
      chk("blk_done", 1, done);
      chk("blk_end", 0, act);
      apb(1'b0, `CCIX_OFF_XCOUNT, 32'h0);
      chk("xcount", 4 * 2, rd);
      apb(1'b1, `CCIX_OFF_CMD, 32'h3014);
      wait_sent();
      chk("stream", 1, xstr);
      chk("rd_dir", 0, xwr);
      bytes(12);
      chk("str_run", 1, act);
      apb(1'b1, `CCIX_OFF_CMD, 32'hc);
      wait_sent();
      chk("str_done", 1, done);
      @(posedge clk);
      chk("str_end", 0, act);
      complete_run();
   end
endmodule
`default_nettype wire
